// [include/pscr_defines.vh]
/*
 * register map, field positions, reset values and timing counts for the phy
 * condition status / special control register pair.
 * assumes: included by bare name from design files; 32-bit apb word per register.
 */
`ifndef PSCR_DEFINES_VH
`define PSCR_DEFINES_VH

// register indices as printed (management space), byte address = 4 * index
`define PSCR_IDX_STATUS       8'h10
`define PSCR_IDX_CONTROL      8'h11
`define PSCR_IDX_IRQ_STATUS   8'h12
`define PSCR_IDX_IRQ_SRC      8'h40
`define PSCR_IDX_IRQ_MASK     8'h41
`define PSCR_IDX_STRAP        8'h42

// status register fields
`define PSCR_ST_RXERR         13
`define PSCR_ST_CHAN_OK       10
`define PSCR_ST_DSCR_LOCK     9
`define PSCR_ST_PIN_HIST      7
`define PSCR_ST_JABBER        5
`define PSCR_ST_LOOPBACK      3
`define PSCR_ST_DUPLEX        2
`define PSCR_ST_LINK          0

// control register fields
`define PSCR_CT_CLK_DIS       15
`define PSCR_CT_PS_EN         14
`define PSCR_CT_PS_HI         13
`define PSCR_CT_PS_LO         12
`define PSCR_CT_SGMII_RST     11
`define PSCR_CT_ISO_ADDR0     10
`define PSCR_CT_FIFO_HI       9
`define PSCR_CT_FIFO_LO       8
`define PSCR_CT_SPARE7        7
`define PSCR_CT_POL           3
`define PSCR_CT_FORCE         2
`define PSCR_CT_IRQ_ON        1
`define PSCR_CT_PIN_OUT       0
`define PSCR_CT_WMASK         16'hFF8F
`define PSCR_CT_RESET         16'h010B

// power save codes
`define PSCR_PS_NORMAL        2'h0
`define PSCR_PS_IEEE_DOWN     2'h1

// interrupt status bits at index 0x12 (event sources of this block)
`define PSCR_IRQ_NUM          4
`define PSCR_IRQ_RXERR        0
`define PSCR_IRQ_LINK         1
`define PSCR_IRQ_CHAN_DROP    2
`define PSCR_IRQ_LOCK_LOSS    3

// sgmii reset pulse: least time in ns, cycles derived at 8 ns per cycle
`define PSCR_SGMII_RST_NS     64
`define PSCR_CLK_NS           8
`define PSCR_SGMII_RST_CYC    ((`PSCR_SGMII_RST_NS + `PSCR_CLK_NS - 1) / `PSCR_CLK_NS)

`endif

// [hdl/pscr_regs.v]
/*
 * phy condition status and special control registers behind an apb slave,
 * with the interrupt pin logic, clock-out gate, power save and isolate outputs.
 * assumes: single pclk domain; phy status inputs and pins come from other
 * domains and are synchronised here; the management address strap is stable
 * after reset release.
 * the slave never inserts wait states; read data is combinational in the
 * access phase, so a master must take it at the pready edge.
 * status inputs reach the register view two cycles late, so a pulse shorter
 * than one pclk period can be missed entirely.
 */
// Design decision made here: the APB register port.
`timescale 1ns/1ns
`include "pscr_defines.vh"

module pscr_regs #(
	parameter ADDR_W = 12
) (
	input  wire              pclk,
	input  wire              presetn,
	input  wire              psel,
	input  wire              penable,
	input  wire              pwrite,
	input  wire [ADDR_W-1:0] paddr,
	input  wire [31:0]       pwdata,
	input  wire [3:0]        pstrb,
	output reg  [31:0]       prdata,
	output wire              pready,
	output wire              pslverr,
	input  wire              rx_error,
	input  wire              channel_ok,
	input  wire              descr_locked,
	input  wire              mii_loopback,
	input  wire              full_duplex,
	input  wire              jabber_seen,
	input  wire              link_up,
	input  wire [4:0]        phy_addr_strap,
	input  wire              irq_pin_in,
	output reg               irq_pin_out,
	output reg               irq_pin_oe,
	output reg               pin_power_down,
	output reg               ref_clock_out_en,
	output reg  [1:0]        power_save_mode,
	output reg               mac_isolate,
	output reg  [3:0]        rmii_fifo_nibbles,
	output reg               sgmii_reset,
	output wire              irq
);

	// two-stage synchronisers for asynchronous status inputs
	reg  [7:0] sync1;          // first stage, read only by sync2
	reg  [7:0] sync2;          // second stage, usable by logic
	wire [7:0] async_in;       // bundled raw inputs
	reg        chan_ok_q;      // previous channel ok for drop detection
	reg        lock_q;         // previous lock for loss detection
	reg        link_q;         // previous link for change detection

	// registers
	reg  [15:0] control;                       // special control word
	reg         rxerr_latch;                   // receive error since last read
	reg         chan_ok_latch;                 // latch-low channel ok
	reg         lock_latch;                    // latch-low descrambler lock
	reg         pin_hist;                      // pin has been asserted
	reg  [`PSCR_IRQ_NUM-1:0] irq_status;       // clear-on-read event bits
	reg  [`PSCR_IRQ_NUM-1:0] irq_src;          // apb sticky status (w1c)
	reg  [`PSCR_IRQ_NUM-1:0] irq_mask;         // apb interrupt mask
	reg  [4:0]  strap;                         // management address caught at release
	reg         strap_taken;                   // strap has been captured
	reg  [3:0]  rst_cnt;                       // sgmii reset pulse counter

	// constant views: writable control bits and the last count of the reset pulse
	localparam integer RST_LAST = `PSCR_SGMII_RST_CYC - 1;
	wire [15:0] ctrl_wmask = `PSCR_CT_WMASK;   // bits 6-4 read back as zero
	wire [31:0] rst_last_w = RST_LAST;         // sliced to the counter width below

	// bus decode
	// only the access phase acts; the setup phase never changes state, so a
	// master that stalls in setup cannot trigger a clear-on-read by accident
	wire        acc   = psel & penable;
	wire        wr    = acc & pwrite;
	wire        rd    = acc & ~pwrite;
	wire [7:0]  idx   = paddr[9:2];
	wire        align = (paddr[1:0] == 2'b00) & (paddr[ADDR_W-1:10] == {(ADDR_W-10){1'b0}});

	wire [15:0] status_word;
	wire [`PSCR_IRQ_NUM-1:0] events;
	wire        pin_active;

	// true when a given index is addressed on an aligned access
	function hit;
		input [7:0] a;
		input [7:0] want;
		input       ok;
		begin
			hit = ok & (a == want);
		end
	endfunction

	// decode of fifo depth code to nibble count
	function [3:0] fifo_depth;
		input [1:0] code;
		begin
			case (code)
				2'b00: fifo_depth = 4'h4;
				2'b01: fifo_depth = 4'h5;
				2'b10: fifo_depth = 4'h6;
				default: fifo_depth = 4'h8;
			endcase
		end
	endfunction

	wire mapped = hit(idx, `PSCR_IDX_STATUS, align) | hit(idx, `PSCR_IDX_CONTROL, align) |
	              hit(idx, `PSCR_IDX_IRQ_STATUS, align) | hit(idx, `PSCR_IDX_IRQ_SRC, align) |
	              hit(idx, `PSCR_IDX_IRQ_MASK, align) | hit(idx, `PSCR_IDX_STRAP, align);

	wire rd_status = rd & hit(idx, `PSCR_IDX_STATUS, align);
	wire rd_irqst  = rd & hit(idx, `PSCR_IDX_IRQ_STATUS, align);
	wire wr_ctrl   = wr & hit(idx, `PSCR_IDX_CONTROL, align);
	wire wr_src    = wr & hit(idx, `PSCR_IDX_IRQ_SRC, align);
	wire wr_mask   = wr & hit(idx, `PSCR_IDX_IRQ_MASK, align);

	// zero wait state slave; unmapped or misaligned access answers with an error
	assign pready  = 1'b1;
	assign pslverr = acc & ~mapped;

	// raw inputs bundled so one synchroniser handles them all
	assign async_in = {
		irq_pin_in,     // 7 shared pin when used as an input
		link_up,        // 6 link state
		jabber_seen,    // 5 jabber indication
		full_duplex,    // 4 duplex mode
		mii_loopback,   // 3 loopback path active
		descr_locked,   // 2 descrambler lock
		channel_ok,     // 1 channel ok
		rx_error        // 0 receive error level
	};

	// synchroniser stages
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			// duplex resets full
			// the duplex stage starts at 1 so the status word reads 0004 out of reset
			sync1 <= 8'h10;
			sync2 <= 8'h10;
		end else begin
			sync1 <= async_in;
			sync2 <= sync1;
		end
	end

	// synchronised views
	wire s_rxerr = sync2[0];
	wire s_chan  = sync2[1];
	wire s_lock  = sync2[2];
	wire s_loop  = sync2[3];
	wire s_dup   = sync2[4];
	wire s_jab   = sync2[5];
	wire s_link  = sync2[6];
	wire s_pin   = sync2[7];

	// event sources: rx error, link change, channel drop, lock loss
	// the previous-value flops reset low like their synchroniser bits, so nothing
	// fires before the first real input sample
	assign events = {lock_q & ~s_lock, chan_ok_q & ~s_chan, link_q ^ s_link, s_rxerr};

	// previous values for edge detection
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			chan_ok_q <= 1'b0;
			lock_q    <= 1'b0;
			link_q    <= 1'b0;
		end else begin
			chan_ok_q <= s_chan;
			lock_q    <= s_lock;
			link_q    <= s_link;
		end
	end

	// status latches; a new event in the read cycle wins over the clear
	// latch-low bits start at 0: software must read once to arm them
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rxerr_latch   <= 1'b0;
			chan_ok_latch <= 1'b0;
			lock_latch    <= 1'b0;
			pin_hist      <= 1'b0;
		end else begin
			if (s_rxerr)
				rxerr_latch <= 1'b1;
			else if (rd_status)
				rxerr_latch <= 1'b0;
			// latch low channel ok
			// a read re-arms the bit to the live level; a drop holds it at 0
			if (~s_chan)
				chan_ok_latch <= 1'b0;
			else if (rd_status)
				chan_ok_latch <= 1'b1;
			if (~s_lock)
				lock_latch <= 1'b0;
			else if (rd_status)
				lock_latch <= 1'b1;
			if (pin_active)
				pin_hist <= 1'b1;
			else if (rd_irqst)
				pin_hist <= 1'b0;
		end
	end

	// clear-on-read event bits and the apb sticky copy
	// both are set by the same events; the sticky copy serves the level irq
	// output, the clear-on-read copy serves the pin and its status readers
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_status <= {`PSCR_IRQ_NUM{1'b0}};
			irq_src    <= {`PSCR_IRQ_NUM{1'b0}};
			irq_mask   <= {`PSCR_IRQ_NUM{1'b0}};
		end else begin
			irq_status <= (rd_irqst ? {`PSCR_IRQ_NUM{1'b0}} : irq_status) | events;
			// set wins over write-one-to-clear
			irq_src    <= (wr_src & pstrb[0] ? irq_src & ~pwdata[`PSCR_IRQ_NUM-1:0] : irq_src) | events;
			if (wr_mask & pstrb[0])
				irq_mask <= pwdata[`PSCR_IRQ_NUM-1:0];
		end
	end

	assign irq = |(irq_src & irq_mask);

	// control register with byte strobes and self-clearing sgmii reset
	// the pulse counter comes first so that a write landing in the clear
	// cycle still wins and starts a fresh pulse
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			control <= `PSCR_CT_RESET;
			rst_cnt <= 4'h0;
		end else begin
			if (control[`PSCR_CT_SGMII_RST]) begin
				if (rst_cnt == rst_last_w[3:0]) begin
					// pulse long enough: drop the bit
					control[`PSCR_CT_SGMII_RST] <= 1'b0;
					rst_cnt <= 4'h0;
				end else begin
					rst_cnt <= rst_cnt + 4'h1;
				end
			end else begin
				// idle: counter parked so every pulse is full length
				rst_cnt <= 4'h0;
			end
			// software write, later in the block so it overrides the self clear
			if (wr_ctrl) begin
				// low byte: bits 6-4 are read-only zero
				if (pstrb[0])
					control[7:0] <= pwdata[7:0] & ctrl_wmask[7:0];
				// high byte fully writable
				if (pstrb[1])
					control[15:8] <= pwdata[15:8];
			end
		end
	end

	// management address strap caught once after reset release
	// caught once so a strap pin reused as a signal later cannot flip isolation
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			strap       <= 5'h00;
			strap_taken <= 1'b0;
		end else if (!strap_taken) begin
			strap       <= phy_addr_strap;
			strap_taken <= 1'b1;
		end
	end

	// combinational so the history flag and the pin see the same cycle
	// global enable gates events
	assign pin_active = control[`PSCR_CT_FORCE] |
	                    (control[`PSCR_CT_IRQ_ON] & (|irq_status));

	// registered block outputs
	// every pin-facing output is a flop so no decode glitch reaches the pads;
	// the cost is one cycle of latency after a control write
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_pin_out       <= 1'b1;
			irq_pin_oe        <= 1'b0;
			pin_power_down    <= 1'b0;
			ref_clock_out_en  <= 1'b1;
			power_save_mode   <= `PSCR_PS_NORMAL;
			mac_isolate       <= 1'b0;
			rmii_fifo_nibbles <= 4'h5;
			sgmii_reset       <= 1'b0;
		end else begin
			// polarity: 1 idles high, asserts low
			irq_pin_out <= pin_active ^ control[`PSCR_CT_POL];
			irq_pin_oe     <= control[`PSCR_CT_PIN_OUT];
			// a power-down request only means something while the pin is an input
			pin_power_down <= ~control[`PSCR_CT_PIN_OUT] & s_pin;
			ref_clock_out_en <= ~control[`PSCR_CT_CLK_DIS];
			// power save takes effect only when enabled
			// reserved codes fall back to normal
			if (control[`PSCR_CT_PS_EN] &&
			    control[`PSCR_CT_PS_HI:`PSCR_CT_PS_LO] == `PSCR_PS_IEEE_DOWN)
				power_save_mode <= `PSCR_PS_IEEE_DOWN;
			else
				power_save_mode <= `PSCR_PS_NORMAL;
			mac_isolate <= control[`PSCR_CT_ISO_ADDR0] & strap_taken & (strap == 5'h00);
			rmii_fifo_nibbles <= fifo_depth(control[`PSCR_CT_FIFO_HI:`PSCR_CT_FIFO_LO]);
			// sgmii reset follows the self-clearing bit one cycle late
			sgmii_reset <= control[`PSCR_CT_SGMII_RST];
		end
	end

	// status word assembly
	// loopback mirror
	assign status_word = {
		2'b00,          // 15:14 reserved
		rxerr_latch,    // 13 receive error since last read
		2'b00,          // 12:11 reserved
		chan_ok_latch,  // 10 latch-low channel ok
		lock_latch,     // 9 latch-low descrambler lock
		1'b0,           // 8 reserved
		pin_hist,       // 7 pin has been asserted
		1'b0,           // 6 reserved
		s_jab,          // 5 jabber copy
		1'b0,           // 4 reserved
		s_loop,         // 3 loopback path active
		s_dup,          // 2 full duplex
		1'b0,           // 1 reserved
		s_link          // 0 link up
	};

	// read data mux; unmapped reads give zero
	// zero outside the access phase too, so the bus idles at a known value
	always @* begin
		prdata = 32'h0000_0000;
		if (rd) begin
			if (hit(idx, `PSCR_IDX_STATUS, align))
				prdata = {16'h0000, status_word};
			else if (hit(idx, `PSCR_IDX_CONTROL, align))
				prdata = {16'h0000, control};
			else if (hit(idx, `PSCR_IDX_IRQ_STATUS, align))
				prdata = {28'h000_0000, irq_status};
			else if (hit(idx, `PSCR_IDX_IRQ_SRC, align))
				prdata = {28'h000_0000, irq_src};
			else if (hit(idx, `PSCR_IDX_IRQ_MASK, align))
				prdata = {28'h000_0000, irq_mask};
			else if (hit(idx, `PSCR_IDX_STRAP, align))
				prdata = {27'h000_0000, strap};
		end
	end

endmodule

// [testbench/pscr_regs_properties.sv]
/* port assertions for the status and control register pair.
   assumes: zero-wait apb, one pclk domain, strap stable after reset. */
`timescale 1ns/1ns
module pscr_props #(
	parameter ADDR_W = 12
) (
	input wire logic              pclk,
	input wire logic              presetn,
	input wire logic              psel,
	input wire logic              penable,
	input wire logic              pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0]       pwdata,
	input wire logic [3:0]        pstrb,
	input wire logic [4:0]        phy_addr_strap,
	input wire logic              irq_pin_out,
	input wire logic              irq_pin_oe,
	input wire logic              ref_clock_out_en,
	input wire logic [1:0]        power_save_mode,
	input wire logic              mac_isolate,
	input wire logic [3:0]        rmii_fifo_nibbles,
	input wire logic              sgmii_reset
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// depth code to nibbles, code 3 jumps to 8
	function automatic logic [3:0] fdep(input logic [1:0] c);
		return (c == 2'h3) ? 4'h8 : 4'h4 + {2'h0, c};
	endfunction
	// accepted control writes; outputs follow two edges later
	sequence s_hi_wr;
		psel && penable && pwrite && paddr == 'h044 && pstrb[1];
	endsequence
	sequence s_lo_wr;
		psel && penable && pwrite && paddr == 'h044 && pstrb[0];
	endsequence
	// reset pulse holds exactly eight cycles, then drops
	sequence s_pulse;
		sgmii_reset [*8] ##1 !sgmii_reset;
	endsequence
	a_clk_gate: assert property (s_hi_wr |-> ##2 ref_clock_out_en == !$past(pwdata[15], 2))
		else $error("clock gate wrong");
	a_fifo_depth: assert property (s_hi_wr |-> ##2 rmii_fifo_nibbles == fdep($past(pwdata[9:8], 2)))
		else $error("fifo depth wrong");
	a_power_save: assert property (s_hi_wr |-> ##2 power_save_mode == ($past(pwdata[14:12], 2) == 3'h5 ? 2'h1 : 2'h0))
		else $error("power save wrong");
	a_mac_isolate: assert property (s_hi_wr |-> ##2 mac_isolate == ($past(pwdata[10], 2) && phy_addr_strap == 5'h00))
		else $error("isolate wrong");
	a_pin_dir: assert property (s_lo_wr |-> ##2 irq_pin_oe == $past(pwdata[0], 2))
		else $error("pin direction wrong");
	a_force_pin: assert property (s_lo_wr ##0 pwdata[2] |-> ##2 irq_pin_out == !$past(pwdata[3], 2))
		else $error("forced pin level wrong");
	a_sgmii_pulse: assert property (s_hi_wr ##0 pwdata[11] |-> ##2 s_pulse)
		else $error("sgmii reset pulse wrong");
	a_pin_sleep: assert property (s_lo_wr ##0 pwdata[2:1] == 2'h0 |-> ##2 irq_pin_out == $past(pwdata[3], 2))
		else $error("disabled pin not idle");
endmodule
bind pscr_regs pscr_props #(.ADDR_W(ADDR_W)) i_pscr_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
	.pwdata, .pstrb, .phy_addr_strap, .irq_pin_out, .irq_pin_oe, .ref_clock_out_en, .power_save_mode,
	.mac_isolate, .rmii_fifo_nibbles, .sgmii_reset);

// [testbench/test_phy_status_and_intr_config_regs.sv]
/* self-checking bench for the register pair: apb master, event stimulus, checks.
   assumes: zero-wait slave, status inputs pass a two-flop synchroniser. */
`timescale 1ns/1ns
module test_phy_status_and_intr_config_regs;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q, v;
	logic [3:0]  pstrb, rmii_fifo_nibbles;
	logic [1:0]  power_save_mode;
	logic [4:0]  phy_addr_strap;
	logic        rx_error, channel_ok, descr_locked, mii_loopback, full_duplex, jabber_seen, link_up;
	logic        irq_pin_in, irq_pin_out, irq_pin_oe, pin_power_down, ref_clock_out_en, mac_isolate, sgmii_reset;
	int          miscompares, checks_done, seed;
	pscr_regs i_pscr_regs (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
		.pslverr, .rx_error, .channel_ok, .descr_locked, .mii_loopback, .full_duplex, .jabber_seen, .link_up,
		.phy_addr_strap, .irq_pin_in, .irq_pin_out, .irq_pin_oe, .pin_power_down, .ref_clock_out_en,
		.power_save_mode, .mac_isolate, .rmii_fifo_nibbles, .sgmii_reset, .irq);
	task conclude();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			miscompares++;
			$display("Error %0t: got %h want %h", $time, got, exp);
		end
	endtask
	// one apb transfer; read data and error taken at the pready edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no local limit: the watchdog ends a wait that never finishes
		do begin
			@(posedge pclk);
			q = prdata;
			er = pslverr;
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task wt(input int n);
		repeat (n) @(posedge pclk);
	endtask
	function automatic logic [3:0] fdep(input logic [1:0] c);
		return (c == 2'h3) ? 4'h8 : 4'h4 + {2'h0, c};
	endfunction
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	// watchdog far beyond the expected run
	initial begin
		#40000;
		miscompares++;
		conclude();
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, rx_error, channel_ok, descr_locked} = '0;
		{mii_loopback, jabber_seen, link_up, phy_addr_strap, irq_pin_in} = '0;
		full_duplex = 1'b1;
		pstrb = 4'hf;
		seed = 99;
		wt(2);
		presetn <= 1'b1;
		wt(3);
		apb(0, 12'h044, 0); chk(q, 32'h0000_010b);
		apb(0, 12'h040, 0); chk(q, 32'h0000_0004);
		// corners first, then random words; bit 11 kept out here
		for (int i = 0; i < 10; i++) begin
			v = (i == 0) ? 32'h0000_f7ff : (i == 1) ? 32'h0000_510b : (i == 2) ? 0 : $random(seed) & 32'h0000_f7ff;
			apb(1, 12'h044, v);
			apb(0, 12'h044, 0); chk(q, v & 32'h0000_ff8f);
			chk({22'h0, ref_clock_out_en, power_save_mode, mac_isolate, rmii_fifo_nibbles, irq_pin_oe, irq_pin_out},
				{22'h0, !v[15], (v[14:12] == 3'h5) ? 2'h1 : 2'h0, v[10], fdep(v[9:8]), v[0], v[2] ^ v[3]});
		end
		apb(1, 12'h044, 32'h0000_0103);
		mii_loopback <= 1'b1;
		full_duplex <= 1'b0;
		link_up <= 1'b1;
		jabber_seen <= 1'b1;
		wt(4);
		apb(0, 12'h040, 0); chk(q & 32'h0000_00ad, 32'h0000_00a9);
		chk(irq_pin_out, 1);
		chk(irq, 0);
		apb(1, 12'h104, 32'h0000_0002); chk(irq, 1);
		apb(1, 12'h100, 32'h0000_0002); chk(irq, 0);
		apb(0, 12'h048, 0); chk(q, 32'h0000_0002);
		apb(0, 12'h048, 0); chk(q, 0);
		apb(0, 12'h040, 0); chk(q & 32'h0000_0080, 0);
		chk(irq_pin_out, 0);
		// error pulse plus latch-low inputs coming up
		channel_ok <= 1'b1;
		descr_locked <= 1'b1;
		rx_error <= 1'b1;
		wt(2);
		rx_error <= 1'b0;
		wt(4);
		apb(0, 12'h040, 0); chk(q & 32'h0000_2600, 32'h0000_2000);
		apb(0, 12'h040, 0); chk(q & 32'h0000_2600, 32'h0000_0600);
		channel_ok <= 1'b0;
		descr_locked <= 1'b0;
		wt(3);
		channel_ok <= 1'b1;
		descr_locked <= 1'b1;
		wt(4);
		apb(0, 12'h040, 0); chk(q & 32'h0000_0600, 0);
		apb(0, 12'h040, 0); chk(q & 32'h0000_0600, 32'h0000_0600);
		apb(0, 12'h048, 0);
		apb(0, 12'h048, 0);
		apb(1, 12'h044, 32'h0000_0101);
		channel_ok <= 1'b0;
		wt(3);
		channel_ok <= 1'b1;
		wt(4);
		chk(irq_pin_out, 0);
		apb(0, 12'h048, 0); chk(q & 32'h0000_0004, 32'h0000_0004);
		apb(1, 12'h044, 32'h0000_0901);
		apb(0, 12'h044, 0); chk(q & 32'h0000_0800, 32'h0000_0800);
		chk(sgmii_reset, 1);
		wt(12);
		apb(0, 12'h044, 0); chk(q & 32'h0000_0800, 0);
		chk(sgmii_reset, 0);
		apb(1, 12'h044, 32'h0000_0100);
		irq_pin_in <= 1'b1;
		wt(4);
		chk({irq_pin_oe, pin_power_down}, 2'b01);
		apb(0, 12'h200, 0); chk({31'h0000_0000, er}, 32'h0000_0001);
		chk(q, 32'h0000_0000);
		// second reset with a nonzero strap: isolation must stay off
		phy_addr_strap <= 5'h05;
		presetn <= 1'b0;
		wt(2);
		presetn <= 1'b1;
		wt(3);
		apb(0, 12'h044, 0); chk(q, 32'h0000_010b);
		apb(1, 12'h044, 32'h0000_050b);
		apb(0, 12'h108, 0); chk(q, 32'h0000_0005);
		chk(mac_isolate, 0);
		conclude();
	end
endmodule
